//--- core/cmp_latch_pkg.sv
// Package for the comparator SR latch control block: register map,
// field positions, reset values and set-clock prescale decode.
// Assumes a single 25 MHz system clock and an 8-bit register port.
package cmp_latch_pkg;

  localparam int REG_ADDR_W = 2;
  localparam int REG_DATA_W = 8;

  localparam logic [REG_ADDR_W-1:0] COMPARATOR_AUX_CONTROL_OFS = 2'h0;
  localparam logic [REG_ADDR_W-1:0] LATCH_CONTROL_OFS = 2'h1;
  localparam logic [REG_ADDR_W-1:0] LATCH_CLOCK_CONTROL_OFS = 2'h2;

  localparam logic [7:0] COMPARATOR_AUX_CONTROL_RST = 8'h02;
  localparam logic [7:0] LATCH_CONTROL_RST = 8'h00;
  localparam logic [7:0] LATCH_CLOCK_CONTROL_RST = 8'h00;

  // Auxiliary comparator control fields
  localparam int AUX_MIRROR_A_BIT = 7;
  localparam int AUX_MIRROR_B_BIT = 6;
  localparam int AUX_ALT_CLOCK_BIT = 4;
  localparam int AUX_HYS_A_BIT = 3;
  localparam int AUX_HYS_B_BIT = 2;
  localparam int AUX_GATE_SRC_BIT = 1;
  localparam int AUX_SYNC_B_BIT = 0;

  // Latch control fields
  localparam int LC_MUX_B_BIT = 7;
  localparam int LC_MUX_A_BIT = 6;
  localparam int LC_SET_EN_BIT = 5;
  localparam int LC_RESET_EN_BIT = 4;
  localparam int LC_SOFT_SET_BIT = 3;
  localparam int LC_SOFT_RESET_BIT = 2;
  localparam int LC_CLK_EN_BIT = 0;

  // Latch clock control field
  localparam int LCC_PRESCALE_LSB = 6;
  localparam int LCC_PRESCALE_W = 2;

  localparam int PRESCALE_CNT_W = 7;
  localparam int PRESCALE_BASE_LOG2 = 4;

  localparam int SYNC_STAGES = 2;

  // Terminal count of the set-clock divider: 15, 31, 63 or 127, for periods of 16 to 128 cycles
  function automatic logic [PRESCALE_CNT_W-1:0] prescale_terminal(
    input logic [LCC_PRESCALE_W-1:0] sel
  );
    logic [PRESCALE_CNT_W:0] div;
    div = 8'h01 << (PRESCALE_BASE_LOG2 + int'(sel));
    prescale_terminal = PRESCALE_CNT_W'(div - 8'h01);
  endfunction

endpackage

//--- core/set_clock_if.sv
// Interface between the register logic and the periodic set-clock
// generator. Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none
interface set_clock_if;
  logic enable;
  logic [1:0] prescale;
  logic pulse;
  modport gen (input enable, input prescale, output pulse);
  modport user (output enable, output prescale, input pulse);
endinterface
`default_nettype wire

//--- core/cmp_conditioner.sv
// One comparator path: two-stage synchroniser and digital hysteresis.
// Assumes the analog front end gives the raw trip result and the two
// threshold results as levels, asynchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module cmp_conditioner
  import cmp_latch_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic raw_in,
  input wire logic above_upper_in,
  input wire logic above_lower_in,
  input wire logic hys_en_in,
  output logic cond_out
);

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic cond_reg;
  logic cond_next;

  // First stage is read only by the second
  always_ff @(posedge core_clk_in or negedge nrst_in) begin // see RL20
    if (!nrst_in) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
    end else begin
      meta_reg <= {above_lower_in, above_upper_in, raw_in};
      sync_reg <= meta_reg;
    end
  end

  always_comb begin
    cond_next = cond_reg;
    if (!hys_en_in) begin
      cond_next = sync_reg[0];
    end else if (!cond_reg && sync_reg[1]) begin // see RL2
      cond_next = 1'b1;
    end else if (cond_reg && !sync_reg[2]) begin // see RL3
      cond_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin // see RL1
    if (!nrst_in) begin
      cond_reg <= 1'b0;
    end else begin
      cond_reg <= cond_next;
    end
  end

  assign cond_out = cond_reg;

  AST_HYS_NO_EARLY_RISE: assert property ( // see RL2
    @(posedge core_clk_in) disable iff (!nrst_in)
    hys_en_in && !cond_reg && !sync_reg[1] |=> !cond_reg)
    else $error("hysteresis output rose below upper threshold");

  AST_HYS_NO_EARLY_FALL: assert property ( // see RL3
    @(posedge core_clk_in) disable iff (!nrst_in)
    hys_en_in && cond_reg && sync_reg[2] |=> cond_reg)
    else $error("hysteresis output fell above lower threshold");

endmodule
`default_nettype wire

//--- core/set_clock_gen.sv
// Periodic set-clock generator: divides the system clock by the
// selected prescale and emits one-cycle pulses while enabled.
// Assumes enable and prescale come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module set_clock_gen
  import cmp_latch_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  set_clock_if.gen clk_if
);

  logic [PRESCALE_CNT_W-1:0] count_reg;
  logic pulse_reg;
  logic at_end;
  // Cycles since the last pulse while dividing by 16; zero until a pulse
  logic [PRESCALE_CNT_W-1:0] gap_reg;

  assign at_end = (count_reg >= prescale_terminal(clk_if.prescale)); // see RL17

  always_ff @(posedge core_clk_in or negedge nrst_in) begin // see RL9
    if (!nrst_in) begin
      count_reg <= '0;
    end else if (!clk_if.enable || at_end) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 7'h01;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin // see RL7
    if (!nrst_in) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= clk_if.enable && at_end; // see RL8
    end
  end

  assign clk_if.pulse = pulse_reg;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gap_reg <= '0;
    end else if (!clk_if.enable || clk_if.prescale != 2'h0) begin
      gap_reg <= '0;
    end else if (pulse_reg) begin
      gap_reg <= 7'h01;
    end else if (gap_reg != 7'h00 && gap_reg != 7'h7f) begin
      gap_reg <= gap_reg + 7'h01;
    end
  end

  AST_SET_CLOCK_ONE_CYCLE: assert property ( // see RL21
    @(posedge core_clk_in) disable iff (!nrst_in)
    pulse_reg |=> !pulse_reg)
    else $error("set clock pulse longer than one cycle");

  AST_SET_CLOCK_PERIOD16: assert property ( // see RL17
    @(posedge core_clk_in) disable iff (!nrst_in)
    gap_reg == 7'h0f && clk_if.enable && clk_if.prescale == 2'h0
    |=> pulse_reg)
    else $error("set clock period at divide by 16 is wrong");

endmodule
`default_nettype wire

//--- core/cmp_latch_ctrl.sv
// Comparator SR latch control: register port, comparator conditioning,
// reset-dominant set/reset latch, periodic set clock, output muxes.
// Assumes a 25 MHz core clock, comparator levels from the analog side
// and a register master that never issues read and write together.
`timescale 1ns/1ps
`default_nettype none

// Function
// RL1: One hysteresis enable per comparator in the auxiliary control register.
// RL2: With hysteresis on, output rises only above the upper threshold.
// RL3: With hysteresis on, output falls only below the lower threshold.
// RL4: Comparator outputs set, reset or toggle the single latch.
// RL5: Software bits set or reset the latch regardless of comparators; a soft set here loses to an enabled comparator B reset.
// RL6: Muxes forward latch or raw comparator output per path.
// RL7: Set-clock enable bit gates periodic pulses onto the latch set.
// RL8: Enabled set clock pulses the set input once every period.
// RL9: Two-bit prescale field in second latch register picks set-clock rate.
// RL10: Latch holds state and follows set and reset levels.
// RL11: Both latch inputs are active high.
// RL12: Set input is comparator A path OR software set pulse.
// RL13: Reset input is comparator B path OR software reset pulse.
// RL14: Set and reset high together leave the latch reset.
// RL15: Software set and reset pulse bits clear themselves after a write.
// RL16: Mirror bits show both comparators; reading them disturbs nothing.
// RL17: Prescale 00..11 gives clock divided by 16, 32, 64, 128.
// RL18: After reset muxes forward the raw comparator outputs.
// RL19: Enable bits gate comparator A onto set and B onto reset.
// RL20: Comparator outputs pass a two-stage synchroniser first.
// RL21: Set-clock and software pulses last exactly one clock cycle.
module cmp_latch_ctrl
  import cmp_latch_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [REG_ADDR_W-1:0] reg_addr_in,
  input wire logic [REG_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [REG_DATA_W-1:0] reg_rdata_out,
  input wire logic cmp_a_raw_in,
  input wire logic cmp_a_above_upper_in,
  input wire logic cmp_a_above_lower_in,
  input wire logic cmp_b_raw_in,
  input wire logic cmp_b_above_upper_in,
  input wire logic cmp_b_above_lower_in,
  output logic cmp_a_port_out,
  output logic cmp_b_port_out,
  output logic cmp_a_output_out,
  output logic cmp_b_output_out,
  output logic latch_q_out,
  output logic cmp_a_hysteresis_enable_out,
  output logic cmp_b_hysteresis_enable_out,
  output logic timer_alt_clock_select_out,
  output logic timer_gate_source_select_out,
  output logic cmp_b_output_sync_enable_out
);

  // Writable register fields
  logic timer_alt_clock_select_reg;
  logic cmp_a_hysteresis_enable_reg;
  logic cmp_b_hysteresis_enable_reg;
  logic timer_gate_source_select_reg;
  logic cmp_b_output_sync_enable_reg;
  logic [1:0] latch_output_mux_select_reg;
  logic cmp_a_set_enable_reg;
  logic cmp_b_reset_enable_reg;
  logic latch_set_clock_enable_reg;
  logic [1:0] set_clock_prescale_select_reg;

  logic soft_set_pulse_reg;
  logic soft_reset_pulse_reg;
  logic latch_q_reg;
  logic [REG_DATA_W-1:0] rdata_reg;
  logic cmp_a_port_reg;
  logic cmp_b_port_reg;
  logic cmp_a_out_reg;
  logic cmp_b_out_reg;

  logic cmp_a_output;
  logic cmp_b_output;
  logic latch_set;
  logic latch_reset;
  logic wr_aux;
  logic wr_lc;
  logic wr_lcc;
  logic [REG_DATA_W-1:0] rdata_next;

  set_clock_if clk_if ();

  cmp_conditioner u_cond_a (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .raw_in(cmp_a_raw_in),
    .above_upper_in(cmp_a_above_upper_in),
    .above_lower_in(cmp_a_above_lower_in),
    .hys_en_in(cmp_a_hysteresis_enable_reg),
    .cond_out(cmp_a_output)
  );

  cmp_conditioner u_cond_b (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .raw_in(cmp_b_raw_in),
    .above_upper_in(cmp_b_above_upper_in),
    .above_lower_in(cmp_b_above_lower_in),
    .hys_en_in(cmp_b_hysteresis_enable_reg),
    .cond_out(cmp_b_output)
  );

  assign clk_if.enable = latch_set_clock_enable_reg; // see RL7
  assign clk_if.prescale = set_clock_prescale_select_reg; // see RL9

  set_clock_gen u_set_clock (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .clk_if(clk_if)
  );

  assign wr_aux = reg_wr_in && (reg_addr_in == COMPARATOR_AUX_CONTROL_OFS);
  assign wr_lc = reg_wr_in && (reg_addr_in == LATCH_CONTROL_OFS);
  assign wr_lcc = reg_wr_in && (reg_addr_in == LATCH_CLOCK_CONTROL_OFS);

  // Auxiliary comparator control, writable part
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_alt_clock_select_reg <=
        COMPARATOR_AUX_CONTROL_RST[AUX_ALT_CLOCK_BIT];
      cmp_a_hysteresis_enable_reg <= COMPARATOR_AUX_CONTROL_RST[AUX_HYS_A_BIT];
      cmp_b_hysteresis_enable_reg <= COMPARATOR_AUX_CONTROL_RST[AUX_HYS_B_BIT];
      timer_gate_source_select_reg <=
        COMPARATOR_AUX_CONTROL_RST[AUX_GATE_SRC_BIT];
      cmp_b_output_sync_enable_reg <=
        COMPARATOR_AUX_CONTROL_RST[AUX_SYNC_B_BIT];
    end else if (wr_aux) begin
      timer_alt_clock_select_reg <= reg_wdata_in[AUX_ALT_CLOCK_BIT];
      cmp_a_hysteresis_enable_reg <= reg_wdata_in[AUX_HYS_A_BIT]; // see RL1
      cmp_b_hysteresis_enable_reg <= reg_wdata_in[AUX_HYS_B_BIT]; // see RL1
      timer_gate_source_select_reg <= reg_wdata_in[AUX_GATE_SRC_BIT];
      cmp_b_output_sync_enable_reg <= reg_wdata_in[AUX_SYNC_B_BIT];
    end
  end

  // Latch control, persistent fields
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      latch_output_mux_select_reg <= LATCH_CONTROL_RST[7:6]; // see RL18
      cmp_a_set_enable_reg <= LATCH_CONTROL_RST[LC_SET_EN_BIT];
      cmp_b_reset_enable_reg <= LATCH_CONTROL_RST[LC_RESET_EN_BIT];
      latch_set_clock_enable_reg <= LATCH_CONTROL_RST[LC_CLK_EN_BIT];
    end else if (wr_lc) begin
      latch_output_mux_select_reg <= {reg_wdata_in[LC_MUX_B_BIT],
                                      reg_wdata_in[LC_MUX_A_BIT]};
      cmp_a_set_enable_reg <= reg_wdata_in[LC_SET_EN_BIT]; // see RL19
      cmp_b_reset_enable_reg <= reg_wdata_in[LC_RESET_EN_BIT]; // see RL19
      latch_set_clock_enable_reg <= reg_wdata_in[LC_CLK_EN_BIT]; // see RL7
    end
  end

  // Software pulses last one cycle and clear themselves
  always_ff @(posedge core_clk_in or negedge nrst_in) begin // see RL15
    if (!nrst_in) begin
      soft_set_pulse_reg <= LATCH_CONTROL_RST[LC_SOFT_SET_BIT];
      soft_reset_pulse_reg <= LATCH_CONTROL_RST[LC_SOFT_RESET_BIT];
    end else begin
      soft_set_pulse_reg <= wr_lc && reg_wdata_in[LC_SOFT_SET_BIT]; // see RL21
      soft_reset_pulse_reg <= wr_lc && reg_wdata_in[LC_SOFT_RESET_BIT];
    end
  end

  // Latch clock control
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      set_clock_prescale_select_reg <=
        LATCH_CLOCK_CONTROL_RST[LCC_PRESCALE_LSB +: LCC_PRESCALE_W];
    end else if (wr_lcc) begin
      set_clock_prescale_select_reg <= // see RL9
        reg_wdata_in[LCC_PRESCALE_LSB +: LCC_PRESCALE_W];
    end
  end

  // Latch inputs
  assign latch_set = (cmp_a_set_enable_reg && cmp_a_output) // see RL12
                     || soft_set_pulse_reg || clk_if.pulse; // see RL8
  assign latch_reset = (cmp_b_reset_enable_reg && cmp_b_output) // see RL13
                       || soft_reset_pulse_reg; // see RL5

  // Reset-dominant latch, sampled every cycle on input levels
  always_ff @(posedge core_clk_in or negedge nrst_in) begin // see RL10
    if (!nrst_in) begin
      latch_q_reg <= 1'b0;
    end else if (latch_reset) begin // see RL14
      latch_q_reg <= 1'b0;
    end else if (latch_set) begin // see RL4, RL11
      latch_q_reg <= 1'b1;
    end
  end

  // Output muxes toward the port logic
  always_ff @(posedge core_clk_in or negedge nrst_in) begin // see RL6
    if (!nrst_in) begin
      cmp_a_port_reg <= 1'b0;
      cmp_b_port_reg <= 1'b0;
      cmp_a_out_reg <= 1'b0;
      cmp_b_out_reg <= 1'b0;
    end else begin
      cmp_a_port_reg <= latch_output_mux_select_reg[0] ? latch_q_reg
                                                       : cmp_a_output;
      cmp_b_port_reg <= latch_output_mux_select_reg[1] ? !latch_q_reg
                                                       : cmp_b_output;
      cmp_a_out_reg <= cmp_a_output;
      cmp_b_out_reg <= cmp_b_output;
    end
  end

  // Read mux; reads have no side effects
  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr_in)
      COMPARATOR_AUX_CONTROL_OFS: begin
        rdata_next[AUX_MIRROR_A_BIT] = cmp_a_output; // see RL16
        rdata_next[AUX_MIRROR_B_BIT] = cmp_b_output; // see RL16
        rdata_next[AUX_ALT_CLOCK_BIT] = timer_alt_clock_select_reg;
        rdata_next[AUX_HYS_A_BIT] = cmp_a_hysteresis_enable_reg;
        rdata_next[AUX_HYS_B_BIT] = cmp_b_hysteresis_enable_reg;
        rdata_next[AUX_GATE_SRC_BIT] = timer_gate_source_select_reg;
        rdata_next[AUX_SYNC_B_BIT] = cmp_b_output_sync_enable_reg;
      end
      LATCH_CONTROL_OFS: begin
        rdata_next[LC_MUX_B_BIT] = latch_output_mux_select_reg[1];
        rdata_next[LC_MUX_A_BIT] = latch_output_mux_select_reg[0];
        rdata_next[LC_SET_EN_BIT] = cmp_a_set_enable_reg;
        rdata_next[LC_RESET_EN_BIT] = cmp_b_reset_enable_reg;
        rdata_next[LC_SOFT_SET_BIT] = soft_set_pulse_reg;
        rdata_next[LC_SOFT_RESET_BIT] = soft_reset_pulse_reg;
        rdata_next[LC_CLK_EN_BIT] = latch_set_clock_enable_reg;
      end
      LATCH_CLOCK_CONTROL_OFS: begin
        rdata_next[LCC_PRESCALE_LSB +: LCC_PRESCALE_W] =
          set_clock_prescale_select_reg;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd_in ? rdata_next : 8'h00;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign cmp_a_port_out = cmp_a_port_reg;
  assign cmp_b_port_out = cmp_b_port_reg;
  assign cmp_a_output_out = cmp_a_out_reg;
  assign cmp_b_output_out = cmp_b_out_reg;
  assign latch_q_out = latch_q_reg;
  assign cmp_a_hysteresis_enable_out = cmp_a_hysteresis_enable_reg;
  assign cmp_b_hysteresis_enable_out = cmp_b_hysteresis_enable_reg;
  assign timer_alt_clock_select_out = timer_alt_clock_select_reg;
  assign timer_gate_source_select_out = timer_gate_source_select_reg;
  assign cmp_b_output_sync_enable_out = cmp_b_output_sync_enable_reg;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  AST_SOFT_SET_FROM_WRITE: assert property ( // see RL15
    wr_lc && reg_wdata_in[LC_SOFT_SET_BIT] |=> soft_set_pulse_reg ##1
    !soft_set_pulse_reg || $past(wr_lc && reg_wdata_in[LC_SOFT_SET_BIT]))
    else $error("software set pulse not generated or not cleared");

  AST_SOFT_RESET_ONE_CYCLE: assert property ( // see RL21
    soft_reset_pulse_reg && !$past(wr_lc) |-> 1'b0)
    else $error("software reset pulse held without a write");

  AST_RESET_DOMINANT: assert property ( // see RL14
    latch_set && latch_reset |=> !latch_q_reg)
    else $error("latch not reset when set and reset both high");

  AST_SET_ONLY: assert property ( // see RL11
    latch_set && !latch_reset |=> latch_q_reg)
    else $error("latch not set by set input");

  AST_HOLD_STATE: assert property ( // see RL10
    !latch_set && !latch_reset |=> $stable(latch_q_reg))
    else $error("latch changed without an input");

  AST_SOFT_RESET_WINS: assert property ( // see RL5
    soft_reset_pulse_reg |=> !latch_q_reg)
    else $error("software reset did not clear latch");

  AST_CMP_A_SETS: assert property ( // see RL4
    cmp_a_output && cmp_a_set_enable_reg && !latch_reset
    |=> latch_q_reg)
    else $error("comparator A path did not set latch");

  AST_CMP_B_GATED: assert property ( // see RL19
    cmp_b_output && !cmp_b_reset_enable_reg && !soft_reset_pulse_reg
    && latch_q_reg |=> latch_q_reg)
    else $error("comparator B reset latch while not enabled");

  AST_CLOCK_GATED: assert property ( // see RL7
    !latch_set_clock_enable_reg ##1 !latch_set_clock_enable_reg
    |-> !clk_if.pulse)
    else $error("set clock pulse while disabled");

  AST_PORT_A_MUX: assert property ( // see RL6
    ##1 cmp_a_port_reg == ($past(latch_output_mux_select_reg[0])
      ? $past(latch_q_reg) : $past(cmp_a_output)))
    else $error("port A mux output wrong");

  AST_PORT_B_MUX: assert property ( // see RL18
    !latch_output_mux_select_reg[1] |=> cmp_b_port_reg == $past(cmp_b_output))
    else $error("port B not forwarding raw comparator");

  AST_MIRROR_READ: assert property ( // see RL16
    reg_rd_in && reg_addr_in == COMPARATOR_AUX_CONTROL_OFS
    |=> reg_rdata_out[7:6] == $past({cmp_a_output, cmp_b_output}))
    else $error("mirror bits do not match comparator outputs");

endmodule
`default_nettype wire

//--- tb/cmp_front_model.sv
// Behavioural analog front end of one comparator: turns an input level
// into the trip result and the two hysteresis threshold results.
// Assumes the bench moves the level right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module cmp_front_model #(
  parameter logic [7:0] TRIP = 8'h80,
  parameter logic [7:0] BAND = 8'h10
) (
  input wire logic [7:0] vin_in,
  output logic raw_out,
  output logic above_upper_out,
  output logic above_lower_out
);
  // Thresholds sit one band either side of the trip point
  assign raw_out = (vin_in > TRIP);
  assign above_upper_out = (vin_in > (TRIP + BAND));
  assign above_lower_out = (vin_in > (TRIP - BAND));
endmodule
`default_nettype wire

//--- tb/test_cmp_latch_ctrl.sv
// Self-checking bench for the comparator latch control block.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
  end \
end
module test_cmp_latch_ctrl;
  import cmp_latch_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] vin_a = 8'h40;
  logic [7:0] vin_b = 8'h40;
  logic a_raw, a_up, a_lo, b_raw, b_up, b_lo;
  logic port_a, port_b, out_a, out_b, latch_q;
  logic hys_a, hys_b, alt_clk, gate_src, sync_b;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int t0, t1, t2, n;

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  cmp_front_model u_cmp_front_model_a (.vin_in(vin_a), .raw_out(a_raw),
    .above_upper_out(a_up), .above_lower_out(a_lo));
  cmp_front_model u_cmp_front_model_b (.vin_in(vin_b), .raw_out(b_raw),
    .above_upper_out(b_up), .above_lower_out(b_lo));

  cmp_latch_ctrl u_cmp_latch_ctrl (
    .core_clk_in(core_clk), .nrst_in(nrst), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .cmp_a_raw_in(a_raw),
    .cmp_a_above_upper_in(a_up), .cmp_a_above_lower_in(a_lo),
    .cmp_b_raw_in(b_raw), .cmp_b_above_upper_in(b_up),
    .cmp_b_above_lower_in(b_lo), .cmp_a_port_out(port_a),
    .cmp_b_port_out(port_b), .cmp_a_output_out(out_a),
    .cmp_b_output_out(out_b), .latch_q_out(latch_q),
    .cmp_a_hysteresis_enable_out(hys_a),
    .cmp_b_hysteresis_enable_out(hys_b),
    .timer_alt_clock_select_out(alt_clk),
    .timer_gate_source_select_out(gate_src),
    .cmp_b_output_sync_enable_out(sync_b));

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("register read", exp, reg_rdata)
  endtask

  // Level change is seen after synchroniser and hysteresis stages
  task automatic set_vin(input logic [7:0] a, input logic [7:0] b);
    @(posedge core_clk);
    vin_a <= a;
    vin_b <= b;
    wait_cyc(8);
  endtask

  // Waits for the latch to rise and returns the cycle number
  task automatic wait_q(output int t);
    t = -1;
    for (int i = 0; i < 300 && t < 0; i++) begin
      @(posedge core_clk);
      #1;
      if (latch_q === 1'b1) t = cyc;
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    `CHK("ports after reset", 3'b000, {port_a, port_b, latch_q})
    rd_chk(LATCH_CONTROL_OFS, 8'h00);
    rd_chk(LATCH_CLOCK_CONTROL_OFS, 8'h00);
    rd_chk(COMPARATOR_AUX_CONTROL_OFS, 8'h02);
    rd_chk(2'h3, 8'h00);
    // Writable fields, read-only mirrors, unmapped index
    wr_reg(COMPARATOR_AUX_CONTROL_OFS, 8'hff);
    wr_reg(2'h3, 8'hff);
    rd_chk(COMPARATOR_AUX_CONTROL_OFS, 8'h1f);
    `CHK("aux fields", 5'h1f, {alt_clk, hys_a, hys_b, gate_src, sync_b})
    rd_chk(2'h3, 8'h00);
    wr_reg(LATCH_CLOCK_CONTROL_OFS, 8'hff);
    rd_chk(LATCH_CLOCK_CONTROL_OFS, 8'hc0);
    // Hysteresis on comparator A only
    wr_reg(COMPARATOR_AUX_CONTROL_OFS, 8'h0a);
    set_vin(8'h88, 8'h88);
    `CHK("hys rise held", 2'b01, {out_a, out_b})
    set_vin(8'hc0, 8'h40);
    `CHK("hys rise", 2'b10, {out_a, out_b})
    set_vin(8'h78, 8'h40);
    `CHK("hys fall held", 1'b1, out_a)
    set_vin(8'h60, 8'h40);
    `CHK("hys fall", 1'b0, out_a)
    wr_reg(COMPARATOR_AUX_CONTROL_OFS, 8'h02);
    // Synchroniser delay and mirror bits
    @(posedge core_clk);
    vin_a <= 8'hc0;
    vin_b <= 8'hc0;
    wait_cyc(2);
    `CHK("sync delay", 2'b00, {out_a, out_b})
    wait_cyc(6);
    `CHK("sync out", 2'b11, {out_a, out_b})
    rd_chk(COMPARATOR_AUX_CONTROL_OFS, 8'hc2);
    rd_chk(COMPARATOR_AUX_CONTROL_OFS, 8'hc2);
    `CHK("raw ports", 3'b110, {port_a, port_b, latch_q})
    // Comparator paths gated by their enables
    set_vin(8'hc0, 8'h40);
    `CHK("set gated off", 1'b0, latch_q)
    wr_reg(LATCH_CONTROL_OFS, 8'h20);
    wait_cyc(3);
    `CHK("cmp set", 1'b1, latch_q)
    wr_reg(LATCH_CONTROL_OFS, 8'h30);
    rd_chk(LATCH_CONTROL_OFS, 8'h30);
    set_vin(8'hc0, 8'hc0);
    `CHK("both high", 1'b0, latch_q)
    set_vin(8'hc0, 8'h40);
    `CHK("toggle back", 1'b1, latch_q)
    set_vin(8'h40, 8'h40);
    `CHK("hold", 1'b1, latch_q)
    // Output muxes follow latch Q and inverted Q
    wr_reg(LATCH_CONTROL_OFS, 8'hc0);
    wait_cyc(3);
    `CHK("mux q", 2'b10, {port_a, port_b})
    wr_reg(LATCH_CONTROL_OFS, 8'hc4);
    wait_cyc(3);
    `CHK("soft reset", 3'b010, {port_a, port_b, latch_q})
    wr_reg(LATCH_CONTROL_OFS, 8'h08);
    rd_chk(LATCH_CONTROL_OFS, 8'h00);
    `CHK("soft set", 1'b1, latch_q)
    wr_reg(LATCH_CONTROL_OFS, 8'h0c);
    wait_cyc(3);
    `CHK("soft both", 1'b0, latch_q)
    // Set clock for every prescale code
    for (int p = 0; p < 4; p++) begin
      n = 16 << p;
      wr_reg(LATCH_CLOCK_CONTROL_OFS, {p[1:0], 6'h00});
      wr_reg(LATCH_CONTROL_OFS, 8'h01);
      t0 = cyc;
      wait_q(t1);
      `CHK("first pulse", 1'b1, (t1 >= t0 + n - 2) && (t1 <= t0 + n + 4))
      wr_reg(LATCH_CONTROL_OFS, 8'h05);
      wait_q(t2);
      `CHK("pulse period", n, t2 - t1)
      wr_reg(LATCH_CONTROL_OFS, 8'h04);
      wait_cyc(2 * n + 4);
      `CHK("clock gated", 1'b0, latch_q)
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
